// >>> lds_checker.sv
// assertion checker for the diagnostic status bank
`timescale 1ns/1ps
`default_nettype none
`include "lds_defines.svh"
module lds_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic off_mode,
  input wire logic clr_errors,
  input wire lds_pkg::lds_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic gate_drv_en,
  input wire logic [2:0] gate_force_low,
  input wire logic meas_update_en,
  input wire logic gate_supply_fault_flag,
  input wire logic gate_supply_good_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic rd_on;
  assign rd_on = bus.rd && !off_mode;
  chk_fault_gate_off: assert property (
    gate_supply_fault_flag |-> !gate_drv_en && gate_force_low == 3'h7)
    else $error("gate drive active during fault");
  chk_fault_good_low: assert property (
    gate_supply_fault_flag |-> !gate_supply_good_flag)
    else $error("good flag set during fault");
  chk_fault_meas_stop: assert property (
    gate_supply_fault_flag |-> !meas_update_en)
    else $error("measurement updates during fault");
  chk_fault_clear_cause: assert property (
    $fell(gate_supply_fault_flag) |->
      $past(clr_errors) || $past(off_mode) || !$past(rst_n))
    else $error("fault flag cleared without cause");
  chk_copy_rsv_zero: assert property (
    rd_on && bus.addr == `LDS_ADDR_COPY_REQ |=> rdata[7:3] == 5'h00)
    else $error("copy request reserved bits set");
  chk_nvtg_rsv_bits: assert property (
    rd_on && bus.addr == `LDS_ADDR_NVTG_STAT |=> rdata[7:5] == 3'h2)
    else $error("toggle register reserved bits wrong");
  chk_head_rsv_zero: assert property (
    rd_on && bus.addr == `LDS_ADDR_HEAD_STAT |=> rdata[7:6] == 2'h0)
    else $error("headroom register reserved bits set");
  chk_rdata_hold: assert property (
    !bus.rd && !off_mode |=> $stable(rdata))
    else $error("read data moved without a read");
  chk_diag_map: assert property (
    rd_on && bus.addr == `LDS_ADDR_DIAG_MAIN |=>
      rdata[4] == $past(gate_supply_fault_flag) &&
      rdata[3] == $past(gate_supply_good_flag))
    else $error("main register flags misplaced");
  cov_fault: cover property ($rose(gate_supply_fault_flag));
  cov_clear: cover property (clr_errors ##1 !gate_supply_fault_flag);
  cov_good: cover property ($rose(gate_supply_good_flag));
endmodule
`default_nettype wire

// >>> lds_defines.svh
// offsets, field positions, reset values and timing counts of the status bank
`ifndef LDS_DEFINES_SVH
`define LDS_DEFINES_SVH

// register offsets
`define LDS_ADDR_COPY_REQ 8'h06
`define LDS_ADDR_HEAD_STAT 8'h35
`define LDS_ADDR_NVTG_STAT 8'h36
`define LDS_ADDR_DIAG_MAIN 8'h37

// field positions
`define LDS_DIAG_SUPPLY_BIT 7
`define LDS_DIAG_FAULT_BIT 4
`define LDS_DIAG_GOOD_BIT 3
`define LDS_HEAD_LIVE_LSB 3
`define LDS_NVTG_REJ_BIT 4
`define LDS_NVTG_DONE_BIT 3
`define LDS_NVTG_RSV_ONE_BIT 6

// reset values
`define LDS_RST_FLAGS 3'h0
`define LDS_RST_RDATA 8'h00

// timing
`define LDS_CLK_KHZ 125000
`define LDS_VGG_START_MS 12
`define LDS_VGG_RUN_MS 1
`define LDS_GATE_HIGH_MS 1
`define LDS_TIMER_W 21
`define LDS_GATE_W 17

`endif

// >>> lds_host.sv
// microcontroller side register access model
`timescale 1ns/1ps
`default_nettype none
module lds_host (
  input wire logic clk,
  output var lds_pkg::lds_bus_t bus
);
  initial bus = '0;
  // released strobes drop low, address and data show inverted values so nothing stale looks valid
  task automatic xfer(input logic w, input logic r, input logic [7:0] a,
    input logic [7:0] d);
    @(posedge clk);
    #1 bus = '{w, r, a, d};
    @(posedge clk);
    #1 bus = '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// >>> lds_pkg.sv
// types shared by the diagnostic status bank
`include "lds_defines.svh"

package lds_pkg;

  // levels arriving from pins and analog monitors, outside clk's domain
  typedef struct packed {
    logic [2:0] pwm;
    logic [2:0] reached;
    logic [2:0] over_headroom;
    logic [2:0] gate_high;
    logic vgg_at_target;
    logic supply_ok;
  } lds_async_t;

  // register access from the serial interface decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lds_bus_t;

  typedef struct packed {
    lds_async_t s1;
    lds_async_t s2;
    lds_async_t s3;
    lds_async_t stable;
    logic started;
    logic fault;
    logic good;
    logic [`LDS_TIMER_W-1:0] ftimer;
    logic [2:0][`LDS_GATE_W-1:0] gh_cnt;
    logic [2:0] live;
    logic [2:0] last;
    logic [2:0] hr_flag;
    logic [2:0] cut;
    logic [2:0] last_over;
    logic [2:0] req;
    logic [2:0] tog;
    logic nv_rej;
    logic nv_done;
    logic [7:0] rdata;
  } lds_state_t;

endpackage

// >>> lds_status.sv
// diagnostic status bank of a three-channel led buck driver
// How it works
// - fault after 12 ms start, 1 ms run
// - fault stops gate driver, regulator, good flag
// - fault freezes led voltage measurement updates
// - fault cleared by clear command, off, reset
// - good set at target, cleared uv/fault
// - last-cycle flag updates on pwm fall, copy
// - last-cycle flag cleared by uv, headroom
// - copy request copies live, clears, self-clears
// - copy register bits 2:0, rest zero
// - rejected flag bit 4, write clears
// - done flag bit 3, write clears
// - toggle flags set on change, write clears
// - toggle bits 2:0, bit 6 reads one
// - headroom loss cuts gate, sets flag
// - gate resumes once headroom returns
// - headroom flags sticky until register write
// - cleared while idle may reset from sample
// - live reached set when target reached
// - live reached cleared: fall, uv, copy, stuck
// - live bits 5:3, headroom bits 2:0
// - undervoltage stops drive, keeps fault, freezes
// - main register fault 4, good 3, last 2:0
`timescale 1ns/1ps
`default_nettype none
`include "lds_defines.svh"

module lds_status #(
  parameter int unsigned START_CYC = `LDS_VGG_START_MS * `LDS_CLK_KHZ,
  parameter int unsigned RUN_CYC = `LDS_VGG_RUN_MS * `LDS_CLK_KHZ,
  parameter int unsigned GATE_CYC = `LDS_GATE_HIGH_MS * `LDS_CLK_KHZ
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic off_mode,
  input wire lds_pkg::lds_async_t analog_in,
  input wire logic [2:0] chan_on,
  input wire logic clr_errors,
  input wire logic nv_reject,
  input wire logic nv_done,
  input wire lds_pkg::lds_bus_t bus,
  output logic [7:0] rdata,
  output logic gate_drv_en,
  output logic vgg_reg_en,
  output logic [2:0] gate_force_low,
  output logic meas_update_en,
  output logic gate_supply_fault_flag,
  output logic gate_supply_good_flag
);

  lds_pkg::lds_state_t state_r;
  lds_pkg::lds_state_t state_nxt;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] ref_addr);
    addr_hit = (a == ref_addr);
  endfunction

  function automatic logic [7:0] read_value(input logic [7:0] a,
                                            input lds_pkg::lds_state_t s);
    logic [7:0] v;
    v = 8'h00;
    if (addr_hit(a, `LDS_ADDR_COPY_REQ))
    begin
      v[2:0] = s.req;
    end
    else if (addr_hit(a, `LDS_ADDR_HEAD_STAT))
    begin
      v[`LDS_HEAD_LIVE_LSB +: 3] = s.live;
      v[2:0] = s.hr_flag;
    end
    else if (addr_hit(a, `LDS_ADDR_NVTG_STAT))
    begin
      v[`LDS_NVTG_RSV_ONE_BIT] = 1'b1;
      v[`LDS_NVTG_REJ_BIT] = s.nv_rej;
      v[`LDS_NVTG_DONE_BIT] = s.nv_done;
      v[2:0] = s.tog;
    end
    else if (addr_hit(a, `LDS_ADDR_DIAG_MAIN))
    begin
      // supply status is shown live, it is not a sticky flag
      v[`LDS_DIAG_SUPPLY_BIT] = s.stable.supply_ok;
      v[`LDS_DIAG_FAULT_BIT] = s.fault;
      v[`LDS_DIAG_GOOD_BIT] = s.good;
      v[2:0] = s.last;
    end
    read_value = v;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    lds_pkg::lds_async_t st;
    logic [2:0] pwm_fall;
    logic [2:0] pwm_chg;
    logic uv;
    logic failing;
    logic fault_set;
    logic [`LDS_TIMER_W-1:0] limit;
    logic wr_copy;
    logic wr_head;
    logic wr_nvtg;
    logic mon;
    logic hr_live;
    logic hr_ev;
    logic gh_run;
    logic gh_expire;
    logic copy;
    logic live_clr;
    st = '0;
    pwm_fall = 3'h0;
    pwm_chg = 3'h0;
    uv = 1'b0;
    failing = 1'b0;
    fault_set = 1'b0;
    limit = '0;
    mon = 1'b0;
    hr_live = 1'b0;
    hr_ev = 1'b0;
    gh_run = 1'b0;
    gh_expire = 1'b0;
    copy = 1'b0;
    live_clr = 1'b0;
    wr_copy = 1'b0;
    wr_head = 1'b0;
    wr_nvtg = 1'b0;
    state_nxt = state_r;

    // three-stage sampling; a level counts once stages two and three agree
    state_nxt.s1 = analog_in;
    state_nxt.s2 = state_r.s1;
    state_nxt.s3 = state_r.s2;
    // stages that disagree mean the pin is still moving: keep the old level,
    // so a bouncing pin cannot fake a toggle or an edge
    state_nxt.stable = lds_pkg::lds_async_t'(
      (state_r.s2 & state_r.s3) |
      (state_r.stable & (state_r.s2 ^ state_r.s3)));
    st = state_nxt.stable;
    pwm_fall = state_r.stable.pwm & ~st.pwm;
    pwm_chg = state_r.stable.pwm ^ st.pwm;
    uv = ~st.supply_ok;

    wr_copy = bus.wr & addr_hit(bus.addr, `LDS_ADDR_COPY_REQ);
    wr_head = bus.wr & addr_hit(bus.addr, `LDS_ADDR_HEAD_STAT);
    wr_nvtg = bus.wr & addr_hit(bus.addr, `LDS_ADDR_NVTG_STAT);

    // -------------------------------------------------------------
    // gate-drive supply supervision
    // -------------------------------------------------------------
    // timer only runs while the supply is up; uv clears it, never sets fault
    failing = st.supply_ok & ~st.vgg_at_target & ~state_r.fault;
    limit = state_r.started ? `LDS_TIMER_W'(RUN_CYC - 1)
                            : `LDS_TIMER_W'(START_CYC - 1);
    if (failing)
    begin
      if (state_r.ftimer >= limit)
      begin
        fault_set = 1'b1;
        state_nxt.ftimer = '0;
      end
      else
      begin
        state_nxt.ftimer = state_r.ftimer + `LDS_TIMER_W'(1);
      end
    end
    else
    begin
      state_nxt.ftimer = '0;
    end
    // a new failure in the clearing cycle keeps the flag
    if (fault_set)
    begin
      state_nxt.fault = 1'b1;
    end
    else if (clr_errors)
    begin
      state_nxt.fault = 1'b0;
    end

    if (state_nxt.fault | uv)
    begin
      state_nxt.good = 1'b0;
    end
    else if (st.vgg_at_target)
    begin
      state_nxt.good = 1'b1;
    end
    // once regulated, later dropouts use the short run-time timeout
    if (state_nxt.good)
    begin
      state_nxt.started = 1'b1;
    end

    // -------------------------------------------------------------
    // per channel flags
    // -------------------------------------------------------------
    // channels are independent; the loop unrolls into three copies
    for (int i = 0; i < 3; i++)
    begin
      mon = chan_on[i] & st.supply_ok;
      hr_live = mon & st.over_headroom[i];
      if (mon)
      begin
        state_nxt.last_over[i] = st.over_headroom[i];
      end
      // idle channels fall back on the last monitored sample
      hr_ev = mon ? st.over_headroom[i] : state_r.last_over[i];
      // cut follows the live compare, so switching resumes unaided
      state_nxt.cut[i] = hr_live;
      state_nxt.hr_flag[i] = hr_ev |
        (state_r.hr_flag[i] & ~wr_head);

      // stuck-gate counter runs only while gate and pwm are both high
      gh_run = st.gate_high[i] & st.pwm[i];
      gh_expire = gh_run &
        (state_r.gh_cnt[i] == `LDS_GATE_W'(GATE_CYC - 1));
      if (!gh_run || gh_expire)
      begin
        state_nxt.gh_cnt[i] = '0;
      end
      else
      begin
        state_nxt.gh_cnt[i] = state_r.gh_cnt[i] + `LDS_GATE_W'(1);
      end

      // set wins: a channel still at target stays flagged after a clear
      copy = state_r.req[i];
      live_clr = pwm_fall[i] | uv | copy | gh_expire;
      state_nxt.live[i] = st.reached[i] |
        (state_r.live[i] & ~live_clr);

      if (uv || hr_live)
      begin
        state_nxt.last[i] = 1'b0;
      end
      else if (pwm_fall[i] || copy)
      begin
        state_nxt.last[i] = state_r.live[i] | st.reached[i];
      end

      // request lives one cycle, then drops by itself
      state_nxt.req[i] = wr_copy & bus.wdata[i];

      state_nxt.tog[i] = pwm_chg[i] |
        (state_r.tog[i] & ~wr_nvtg);
    end

    // a result pulse in the clearing write cycle survives the clear
    state_nxt.nv_rej = nv_reject | (state_r.nv_rej & ~wr_nvtg);
    state_nxt.nv_done = nv_done | (state_r.nv_done & ~wr_nvtg);

    // unmapped addresses read zero; a read sees the pre-write state
    if (bus.rd)
    begin
      state_nxt.rdata = read_value(bus.addr, state_r);
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // off mode clears everything exactly like a power-on reset
  // synchronous clear keeps the gate outputs free of reset glitches
  always_ff @(posedge clk)
  begin
    if (!rst_n || off_mode)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // enables are plain gates of registered state: no extra cycle of
  // delay between a fault and the drive shutting off
  assign rdata = state_r.rdata;
  assign gate_drv_en = ~state_r.fault &
    state_r.stable.supply_ok;
  assign vgg_reg_en = ~state_r.fault &
    state_r.stable.supply_ok;
  assign gate_force_low = state_r.cut |
    {3{~gate_drv_en}};
  assign meas_update_en = state_r.good & ~state_r.fault &
    state_r.stable.supply_ok;
  assign gate_supply_fault_flag = state_r.fault;
  assign gate_supply_good_flag = state_r.good;

endmodule

`default_nettype wire

// >>> lds_status_tb_top.sv
// self-checking bench for the diagnostic status bank
`timescale 1ns/1ps
`default_nettype none
module lds_status_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic off_mode = 1'b0;
  logic clr_errors = 1'b0;
  logic nv_reject = 1'b0;
  logic nv_done = 1'b0;
  logic [2:0] chan_on = 3'h0;
  lds_pkg::lds_async_t ain = '0;
  lds_pkg::lds_bus_t bus;
  logic [7:0] rdata;
  logic drv, vreg, meas, fault, good;
  logic [2:0] flow;
  logic [7:0] expq[$];
  logic rd_d = 1'b0;
  logic lk_run = 1'b0;
  logic [31:0] rnd = 32'hCF5D;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  initial forever #4 clk = ~clk;
  // pwm link at 64 ns, unrelated to clk
  always #32 if (lk_run) ain.pwm[2] = ~ain.pwm[2];
  lds_status #(.START_CYC(40), .RUN_CYC(10), .GATE_CYC(10)) u_dut (
    .clk(clk), .rst_n(rst_n), .off_mode(off_mode), .analog_in(ain),
    .chan_on(chan_on), .clr_errors(clr_errors), .nv_reject(nv_reject),
    .nv_done(nv_done), .bus(bus), .rdata(rdata), .gate_drv_en(drv),
    .vgg_reg_en(vreg), .gate_force_low(flow), .meas_update_en(meas),
    .gate_supply_fault_flag(fault), .gate_supply_good_flag(good));
  lds_host u_host (.clk(clk), .bus(bus));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    u_host.xfer(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk);
    #1 s = 1'b1;
    @(posedge clk);
    #1 s = 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // read results land the cycle after the taking edge
  always @(posedge clk) rd_d <= bus.rd;
  always @(negedge clk) if (rd_d) chk(rdata, expq.pop_front());
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      tally_and_finish;
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    idle(20);
    rst_n = 1'b1;
    rd(8'h36, 8'h40);
    rd(8'h35, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h10, 8'h00);
    ain.supply_ok = 1'b1;
    ain.vgg_at_target = 1'b1;
    idle(8);
    rd(8'h37, 8'h88);
    rnd = lfsr(rnd);
    ain.pwm[1:0] = rnd[1:0];
    lk_run = 1'b1;
    idle(10);
    lk_run = 1'b0;
    ain.pwm = 3'h0;
    pulse(nv_reject);
    pulse(nv_done);
    idle(6);
    rd(8'h36, 8'h5C | {6'h00, rnd[1:0]});
    u_host.xfer(1'b1, 1'b0, 8'h36, rnd[15:8]);
    rd(8'h36, 8'h40);
    ain.reached[0] = 1'b1;
    idle(6);
    ain.reached[0] = 1'b0;
    idle(6);
    rd(8'h35, 8'h08);
    u_host.xfer(1'b1, 1'b0, 8'h06, 8'h01);
    rd(8'h06, 8'h00);
    rd(8'h35, 8'h00);
    rd(8'h37, 8'h89);
    ain.pwm[0] = 1'b1;
    idle(6);
    ain.pwm[0] = 1'b0;
    idle(6);
    rd(8'h37, 8'h88);
    chan_on = 3'h2;
    ain.over_headroom[1] = 1'b1;
    idle(6);
    chk({5'h00, flow}, 8'h02);
    rd(8'h35, 8'h02);
    chan_on = 3'h0;
    u_host.xfer(1'b1, 1'b0, 8'h35, 8'h00);
    rd(8'h35, 8'h02);
    chan_on = 3'h2;
    ain.over_headroom[1] = 1'b0;
    idle(6);
    chk({5'h00, flow}, 8'h00);
    rd(8'h35, 8'h02);
    u_host.xfer(1'b1, 1'b0, 8'h35, 8'h00);
    rd(8'h35, 8'h00);
    ain.vgg_at_target = 1'b0;
    idle(6);
    chk({7'h00, fault}, 8'h00);
    idle(20);
    chk({4'h0, fault, good, meas, drv}, 8'h08);
    rd(8'h37, 8'h90);
    ain.vgg_at_target = 1'b1;
    idle(6);
    pulse(clr_errors);
    idle(2);
    chk({6'h00, fault, good}, 8'h01);
    ain.reached[0] = 1'b1;
    idle(6);
    u_host.xfer(1'b1, 1'b0, 8'h06, 8'h01);
    ain.reached[0] = 1'b0;
    rd(8'h37, 8'h89);
    ain.supply_ok = 1'b0;
    idle(6);
    rd(8'h37, 8'h00);
    rd(8'h35, 8'h00);
    ain.supply_ok = 1'b1;
    ain.vgg_at_target = 1'b0;
    pulse(off_mode);
    idle(30);
    chk({6'h00, fault, vreg}, 8'h01);
    idle(20);
    chk({6'h00, fault, vreg}, 8'h02);
    pulse(off_mode);
    chk({7'h00, fault}, 8'h00);
    ain.vgg_at_target = 1'b1;
    pulse(nv_done);
    rst_n = 1'b0;
    idle(3);
    rst_n = 1'b1;
    rd(8'h36, 8'h40);
    idle(6);
    ain.reached[2] = 1'b1;
    idle(6);
    ain.reached[2] = 1'b0;
    ain.pwm[2] = 1'b1;
    ain.gate_high[2] = 1'b1;
    rd(8'h35, 8'h20);
    idle(20);
    rd(8'h35, 8'h00);
    ain.pwm[2] = 1'b0;
    ain.gate_high[2] = 1'b0;
    idle(4);
    tally_and_finish;
  end
endmodule
bind lds_status lds_checker u_chk (
  .clk(clk), .rst_n(rst_n), .off_mode(off_mode), .clr_errors(clr_errors),
  .bus(bus), .rdata(rdata), .gate_drv_en(gate_drv_en),
  .gate_force_low(gate_force_low), .meas_update_en(meas_update_en),
  .gate_supply_fault_flag(gate_supply_fault_flag),
  .gate_supply_good_flag(gate_supply_good_flag));
`default_nettype wire
